// file: core/rccs_defs.vh
// constants for the remote common command interpreter
`ifndef RCCS_DEFS_VH
`define RCCS_DEFS_VH

// command op codes
`define RCCS_OP_CLS      4'h0
`define RCCS_OP_ESE      4'h1
`define RCCS_OP_ESE_Q    4'h2
`define RCCS_OP_ESR_Q    4'h3
`define RCCS_OP_IDN_Q    4'h4
`define RCCS_OP_OPC      4'h5
`define RCCS_OP_OPC_Q    4'h6
`define RCCS_OP_RCL      4'h7
`define RCCS_OP_RST      4'h8
`define RCCS_OP_SAV      4'h9
`define RCCS_OP_SET_NUM  4'ha
`define RCCS_OP_SET_BOOL 4'hb

// parameter ranges
`define RCCS_ESE_MAX     40'h00000000ff
`define RCCS_SLOT_MAX    40'h0000000009
`define RCCS_SLOT_MIN    40'h0000000001

// event status bit positions
`define RCCS_ESR_OPC     0
`define RCCS_ESR_EXE     4
`define RCCS_ESR_CME     5

// status byte bit positions
`define RCCS_STB_EAV     2
`define RCCS_STB_MAV     4
`define RCCS_STB_ESB     5

// reset values
`define RCCS_ESE_RST     8'h00
`define RCCS_NUM_RST     40'h0000000000
`define RCCS_BOOL_RST    1'b0

// below ten nano units (in pico units) the step is one pico unit
`define RCCS_FINE_LIM    48'h000000002710
`define RCCS_DECADE      48'h00000000000a

// identification fields, eight characters each; values are arbitrary
`define RCCS_IDN_MAKER   "GENMAKER"
`define RCCS_IDN_MODEL   "AMP00001"
`define RCCS_IDN_SERIAL  "00000000"
`define RCCS_IDN_VER     "REV00.00"
`define RCCS_IDN_LEN     6'h23

`define RCCS_CH_COMMA    8'h2c
`define RCCS_CH_SEMI     8'h3b
`define RCCS_CH_ZERO     8'h30

`endif

// file: core/rccs_quant.v
// numeric setting quantiser: four significant digits, fine step below ten nano
`timescale 1ns/1ps
`default_nettype none
`include "rccs_defs.vh"

module rccs_quant (
	// clock and reset
	input  wire        clk_sys,
	input  wire        arst_n,
	// request
	input  wire        start,
	input  wire [39:0] value_in,
	// result
	output reg         done,
	output reg  [39:0] value_out
);
	localparam [1:0] Q_IDLE  = 2'h0;
	localparam [1:0] Q_SCALE = 2'h1;
	localparam [1:0] Q_ROUND = 2'h2;

	reg  [1:0]  state_r;
	reg  [47:0] v_r;
	reg  [47:0] p_r;
	reg  [47:0] lim_r;
	wire [47:0] rem;
	wire [47:0] rounded;

	// step p_r is 1 below the fine limit, so small values pass unchanged
	assign rem     = v_r % p_r; // [RQ13]
	assign rounded = (v_r - rem) + (((rem << 1) >= p_r) ? p_r : 48'h0);

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_r   <= Q_IDLE;
			v_r       <= 48'h0;
			p_r       <= 48'h1;
			lim_r     <= `RCCS_FINE_LIM;
			done      <= 1'b0;
			value_out <= 40'h0;
		end else begin
			done <= 1'b0;
			case (state_r)
			Q_IDLE: begin
				if (start) begin
					v_r     <= {8'h00, value_in};
					p_r     <= 48'h1;
					lim_r   <= `RCCS_FINE_LIM;
					state_r <= Q_SCALE;
				end
			end
			Q_SCALE: begin
				// widen the step one decade until four digits remain [RQ13]
				if (v_r >= lim_r) begin
					p_r   <= p_r * `RCCS_DECADE;
					lim_r <= lim_r * `RCCS_DECADE;
				end else begin
					state_r <= Q_ROUND;
				end
			end
			Q_ROUND: begin
				value_out <= rounded[39:0];
				done      <= 1'b1;
				state_r   <= Q_IDLE;
			end
			default: begin
				state_r <= Q_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: core/rccs_cmd.v
// remote common command interpreter with status, identification and setup slots
// Functional notes
// RQ1: commands run one at a time; a new one is taken only after the last has finished.
// RQ2: the clear command empties status byte, event status, operation event and error queue.
// RQ3: the enable command loads the event enable register with 0 to 255; its query returns it.
// RQ4: the event enable register is zero at power-on and is left alone by the reset command.
// RQ5: the event status query returns the register and then clears it.
// RQ6: identification answers four comma-separated text fields without quotation marks.
// RQ7: the completion command sets the completion bit once earlier commands have finished.
// RQ8: the completion query answers 1 once earlier commands have finished.
// RQ9: recall takes slot 0 to 9 and loads the settings held there.
// RQ10: slot 0 always holds the power-on settings.
// RQ11: save stores the settings into slot 1 to 9; slot 0 is not a save target.
// RQ12: the reset command restores initial settings and leaves excluded registers untouched.
// RQ13: numeric settings keep four significant digits, with a one pico step below ten nano.
// RQ14: values of one answer are split by commas, answers in one message by semicolons.
// RQ15: a boolean value of zero means off and any other value means on.
// RQ16: an out-of-range parameter changes nothing and records an error.
`timescale 1ns/1ps
`default_nettype none
`include "rccs_defs.vh"

module rccs_cmd (
	// clock and reset
	input  wire        clk_sys,
	input  wire        arst_n,
	// command port
	input  wire        cmd_valid,
	input  wire [3:0]  cmd_op,
	input  wire [39:0] cmd_arg,
	input  wire        cmd_first,
	output reg         cmd_ready,
	// response byte stream
	output reg         rsp_valid,
	output reg  [7:0]  rsp_byte,
	output reg         rsp_last,
	input  wire        rsp_ready,
	// instrument events
	input  wire [7:0]  esr_evt,
	input  wire [15:0] oper_evt,
	// status view
	output reg  [7:0]  ese_val,
	output reg  [7:0]  esr_val,
	output reg  [15:0] oper_val,
	output reg  [7:0]  stb_val,
	output reg  [3:0]  err_count,
	// instrument settings
	output reg  [39:0] set_num,
	output reg         set_bool
);
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_EXEC = 2'h1;
	localparam [1:0] S_SEND = 2'h2;
	localparam [1:0] S_QWT  = 2'h3;

	reg  [1:0]   state_r;
	reg  [3:0]   op_r;
	reg  [39:0]  arg_r;
	reg          first_r;
	reg          ans_r;
	reg  [287:0] rvec_r;
	reg  [5:0]   rem_r;
	reg  [40:0]  cfg_mem [0:9];
	integer      i;

	// exec decode
	reg          esr_clr;
	reg  [7:0]   esr_set;
	reg          err_inc;
	reg          clr_all;
	reg  [7:0]   num_src;
	reg          is_query;
	wire         exec;
	wire         slot_ok_rcl;
	wire         slot_ok_sav;
	wire         q_done;
	wire [39:0]  q_out;

	// response build
	wire [7:0]   d2;
	wire [7:0]   d1;
	wire [7:0]   d0;
	wire [279:0] num_vec;
	wire [5:0]   num_len;
	wire [279:0] idn_vec;
	wire [279:0] pay_vec;
	wire [5:0]   pay_len;
	wire         sep;
	wire [287:0] full_vec;
	wire [5:0]   full_len;

	assign exec        = (state_r == S_EXEC);
	assign slot_ok_rcl = (arg_r <= `RCCS_SLOT_MAX);
	assign slot_ok_sav = (arg_r >= `RCCS_SLOT_MIN) && (arg_r <= `RCCS_SLOT_MAX);

	always @* begin
		esr_clr  = 1'b0;
		esr_set  = 8'h00;
		err_inc  = 1'b0;
		clr_all  = 1'b0;
		num_src  = 8'h00;
		is_query = 1'b0;
		if (exec) begin
			case (op_r)
			`RCCS_OP_CLS: begin
				clr_all = 1'b1; // [RQ2]
			end
			`RCCS_OP_ESE: begin
				if (arg_r > `RCCS_ESE_MAX) begin
					esr_set[`RCCS_ESR_EXE] = 1'b1; // [RQ16]
					err_inc = 1'b1;
				end
			end
			`RCCS_OP_ESE_Q: begin
				num_src  = ese_val; // [RQ3]
				is_query = 1'b1;
			end
			`RCCS_OP_ESR_Q: begin
				num_src  = esr_val;
				esr_clr  = 1'b1; // [RQ5]
				is_query = 1'b1;
			end
			`RCCS_OP_IDN_Q: begin
				is_query = 1'b1;
			end
			`RCCS_OP_OPC: begin
				esr_set[`RCCS_ESR_OPC] = 1'b1; // [RQ7]
			end
			`RCCS_OP_OPC_Q: begin
				num_src  = 8'h01; // [RQ8]
				is_query = 1'b1;
			end
			`RCCS_OP_RCL: begin
				if (!slot_ok_rcl) begin
					esr_set[`RCCS_ESR_EXE] = 1'b1; // [RQ16]
					err_inc = 1'b1;
				end
			end
			`RCCS_OP_SAV: begin
				if (!slot_ok_sav) begin
					esr_set[`RCCS_ESR_EXE] = 1'b1; // [RQ11]
					err_inc = 1'b1;
				end
			end
			`RCCS_OP_RST, `RCCS_OP_SET_NUM, `RCCS_OP_SET_BOOL: begin
				is_query = 1'b0;
			end
			default: begin
				esr_set[`RCCS_ESR_CME] = 1'b1;
				err_inc = 1'b1;
			end
			endcase
		end
	end

	// decimal answer without leading zeros
	assign d2 = `RCCS_CH_ZERO + (num_src / 8'd100);
	assign d1 = `RCCS_CH_ZERO + ((num_src / 8'd10) % 8'd10);
	assign d0 = `RCCS_CH_ZERO + (num_src % 8'd10);
	assign num_vec = (num_src >= 8'd100) ? {d2, d1, d0, 256'h0} :
	                 (num_src >= 8'd10)  ? {d1, d0, 264'h0} : {d0, 272'h0};
	assign num_len = (num_src >= 8'd100) ? 6'h3 : (num_src >= 8'd10) ? 6'h2 : 6'h1;

	// identification fields split by commas, no quotation marks [RQ6]
	assign idn_vec = {`RCCS_IDN_MAKER, `RCCS_CH_COMMA, `RCCS_IDN_MODEL, `RCCS_CH_COMMA,
	                  `RCCS_IDN_SERIAL, `RCCS_CH_COMMA, `RCCS_IDN_VER};
	assign pay_vec = (op_r == `RCCS_OP_IDN_Q) ? idn_vec : num_vec;
	assign pay_len = (op_r == `RCCS_OP_IDN_Q) ? `RCCS_IDN_LEN : num_len;

	// a later answer in the same message is led by a semicolon [RQ14]
	assign sep      = ans_r && !first_r;
	assign full_vec = sep ? {`RCCS_CH_SEMI, pay_vec} : {pay_vec, 8'h00};
	assign full_len = pay_len + {5'h0, sep};

	rccs_quant u_quant (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.start     (exec && (op_r == `RCCS_OP_SET_NUM)),
		.value_in  (arg_r),
		.done      (q_done),
		.value_out (q_out)
	);

	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_r   <= S_IDLE;
			op_r      <= 4'h0;
			arg_r     <= 40'h0;
			first_r   <= 1'b0;
			ans_r     <= 1'b0;
			rvec_r    <= 288'h0;
			rem_r     <= 6'h0;
			cmd_ready <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_byte  <= 8'h00;
			rsp_last  <= 1'b0;
			ese_val   <= `RCCS_ESE_RST; // [RQ4]
			esr_val   <= 8'h00;
			oper_val  <= 16'h0;
			stb_val   <= 8'h00;
			err_count <= 4'h0;
			set_num   <= `RCCS_NUM_RST;
			set_bool  <= `RCCS_BOOL_RST;
			for (i = 0; i < 10; i = i + 1) begin
				cfg_mem[i] <= {`RCCS_BOOL_RST, `RCCS_NUM_RST}; // [RQ10]
			end
		end else begin
			// sticky events; a new event wins over a clear in the same cycle
			esr_val  <= ((esr_clr || clr_all) ? 8'h00 : esr_val) | esr_evt | esr_set; // [RQ5]
			oper_val <= (clr_all ? 16'h0 : oper_val) | oper_evt; // [RQ2]
			if (clr_all) begin
				err_count <= err_inc ? 4'h1 : 4'h0;
			end else if (err_inc && (err_count != 4'hf)) begin
				err_count <= err_count + 4'h1; // [RQ16]
			end
			stb_val <= 8'h00;
			stb_val[`RCCS_STB_EAV] <= (err_count != 4'h0);
			stb_val[`RCCS_STB_MAV] <= rsp_valid;
			stb_val[`RCCS_STB_ESB] <= |(esr_val & ese_val);

			case (state_r)
			S_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					op_r      <= cmd_op;
					arg_r     <= cmd_arg;
					first_r   <= cmd_first;
					cmd_ready <= 1'b0; // [RQ1]
					state_r   <= S_EXEC;
				end
			end
			S_EXEC: begin
				if (first_r) begin
					ans_r <= 1'b0;
				end
				case (op_r)
				`RCCS_OP_ESE: begin
					if (arg_r <= `RCCS_ESE_MAX) begin
						ese_val <= arg_r[7:0]; // [RQ3]
					end
				end
				`RCCS_OP_RCL: begin
					if (slot_ok_rcl) begin
						{set_bool, set_num} <= cfg_mem[arg_r[3:0]]; // [RQ9]
					end
				end
				`RCCS_OP_SAV: begin
					if (slot_ok_sav) begin
						cfg_mem[arg_r[3:0]] <= {set_bool, set_num}; // [RQ11]
					end
				end
				`RCCS_OP_RST: begin
					// the enable register and setup slots are excluded [RQ12]
					set_num  <= `RCCS_NUM_RST;
					set_bool <= `RCCS_BOOL_RST;
				end
				`RCCS_OP_SET_BOOL: begin
					set_bool <= (arg_r != 40'h0); // [RQ15]
				end
				default: begin
					set_bool <= set_bool;
				end
				endcase
				if (op_r == `RCCS_OP_SET_NUM) begin
					state_r <= S_QWT;
				end else if (is_query) begin
					ans_r     <= 1'b1;
					rsp_valid <= 1'b1;
					rsp_byte  <= full_vec[287:280];
					rsp_last  <= (full_len == 6'h1);
					rvec_r    <= full_vec << 8;
					rem_r     <= full_len;
					state_r   <= S_SEND;
				end else begin
					cmd_ready <= 1'b1; // [RQ1]
					state_r   <= S_IDLE;
				end
			end
			S_QWT: begin
				if (q_done) begin
					set_num   <= q_out; // [RQ13]
					cmd_ready <= 1'b1;
					state_r   <= S_IDLE;
				end
			end
			S_SEND: begin
				if (rsp_ready) begin
					if (rem_r == 6'h1) begin
						rsp_valid <= 1'b0;
						rsp_last  <= 1'b0;
						cmd_ready <= 1'b1; // [RQ1]
						state_r   <= S_IDLE;
					end else begin
						rsp_byte <= rvec_r[287:280];
						rvec_r   <= rvec_r << 8;
						rsp_last <= (rem_r == 6'h2);
						rem_r    <= rem_r - 6'h1;
					end
				end
			end
			default: begin
				state_r <= S_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: verification/rccs_cmd_monitor.sv
// assertions on the command port, response stream and status
`timescale 1ns/1ps
`default_nettype none
`include "rccs_defs.vh"
module rccs_cmd_monitor (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        arst_n,
	// command port
	input wire logic        cmd_valid,
	input wire logic [3:0]  cmd_op,
	input wire logic [39:0] cmd_arg,
	input wire logic        cmd_ready,
	// response stream
	input wire logic        rsp_valid,
	input wire logic [7:0]  rsp_byte,
	input wire logic        rsp_last,
	input wire logic        rsp_ready,
	// status and settings
	input wire logic [7:0]  esr_evt,
	input wire logic [15:0] oper_evt,
	input wire logic [7:0]  ese_val,
	input wire logic [7:0]  esr_val,
	input wire logic [15:0] oper_val,
	input wire logic [3:0]  err_count,
	input wire logic [39:0] set_num,
	input wire logic        set_bool
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	wire logic take = cmd_valid && cmd_ready;
	a_busy_after_take: assert property (take |=> !cmd_ready)
		else $error("ready high right after a take");
	a_opc_sets: assert property (take && cmd_op == `RCCS_OP_OPC |-> ##2 cmd_ready && esr_val[0])
		else $error("completion bit or ready missing");
	a_cls_clears: assert property (take && cmd_op == `RCCS_OP_CLS ##1 !esr_evt && !oper_evt
		|=> !esr_val && !oper_val && !err_count)
		else $error("clear left status behind");
	a_ese_load: assert property (take && cmd_op == `RCCS_OP_ESE && cmd_arg <= 40'hff
		|-> ##2 ese_val == $past(cmd_arg[7:0], 2))
		else $error("enable register not loaded");
	a_rst_keeps: assert property (take && cmd_op == `RCCS_OP_RST
		|-> ##2 ese_val == $past(ese_val, 2) && !set_bool && !set_num)
		else $error("reset command wrong");
	a_bad_save: assert property (take && cmd_op == `RCCS_OP_SAV && !cmd_arg
		|-> ##2 esr_val[4] && set_num == $past(set_num, 2))
		else $error("save to slot zero not refused");
	a_bool_map: assert property (take && cmd_op == `RCCS_OP_SET_BOOL
		|-> ##2 set_bool == ($past(cmd_arg, 2) != 40'h0))
		else $error("boolean setting wrong");
	a_rsp_hold: assert property (rsp_valid && !rsp_ready
		|=> rsp_valid && $stable(rsp_byte) && $stable(rsp_last))
		else $error("response byte dropped while stalled");
	a_num_bound: assert property (take && cmd_op == `RCCS_OP_SET_NUM |-> ##[2:16] cmd_ready)
		else $error("numeric setting never finished");
	c_idn: cover property (take && cmd_op == `RCCS_OP_IDN_Q);
	c_stall: cover property (rsp_valid && !rsp_ready);
	c_rcl: cover property (take && cmd_op == `RCCS_OP_RCL);
endmodule
bind rccs_cmd rccs_cmd_monitor mon_u (.clk_sys, .arst_n, .cmd_valid, .cmd_op, .cmd_arg,
	.cmd_ready, .rsp_valid, .rsp_byte, .rsp_last, .rsp_ready, .esr_evt, .oper_evt,
	.ese_val, .esr_val, .oper_val, .err_count, .set_num, .set_bool);
`default_nettype wire

// file: verification/rccs_host_model.sv
// remote controller model: reads response bytes, optionally stalling
`timescale 1ns/1ps
`default_nettype none
module rccs_host_model (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        arst_n,
	// pacing
	input wire logic        slow,
	// response stream
	input wire logic        rsp_valid,
	input wire logic [7:0]  rsp_byte,
	input wire logic        rsp_last,
	output logic            rsp_ready,
	// received count
	output int              rx_n
);
	// each entry keeps the end-of-answer flag above the byte
	logic [8:0] rx_q [0:255];
	logic       stall_r;
	assign rsp_ready = !(slow && stall_r);
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rx_n    <= 0;
			stall_r <= 1'b0;
		end else begin
			stall_r <= !stall_r;
			if (rsp_valid && rsp_ready) begin
				rx_q[rx_n] <= {rsp_last, rsp_byte};
				rx_n       <= rx_n + 1;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/test_rccs_cmd.sv
// self-checking bench for the common command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "rccs_defs.vh"
module test_rccs_cmd;
	logic        clk_sys = 0;
	logic        arst_n = 0;
	logic        cmd_valid = 0;
	logic        cmd_first = 0;
	logic        slow = 0;
	logic [3:0]  cmd_op = 0;
	logic [39:0] cmd_arg = 0;
	logic [7:0]  esr_evt = 0;
	logic [15:0] oper_evt = 0;
	logic        cmd_ready, rsp_valid, rsp_last, rsp_ready, set_bool;
	logic [7:0]  rsp_byte, ese_val, esr_val, stb_val;
	logic [15:0] oper_val;
	logic [3:0]  err_count;
	logic [39:0] set_num;
	int          rx_n, rb = 0, error_cnt = 0, total_checks = 0;
	rccs_cmd dut_u (.clk_sys, .arst_n, .cmd_valid, .cmd_op, .cmd_arg, .cmd_first,
		.cmd_ready, .rsp_valid, .rsp_byte, .rsp_last, .rsp_ready, .esr_evt, .oper_evt,
		.ese_val, .esr_val, .oper_val, .stb_val, .err_count, .set_num, .set_bool);
	rccs_host_model host_u (.clk_sys, .arst_n, .slow, .rsp_valid, .rsp_byte, .rsp_last,
		.rsp_ready, .rx_n);
	always #4 clk_sys = ~clk_sys;
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic do_cmd(input logic [3:0] op, input logic [39:0] arg, input logic first);
		cmd_valid <= 1'b1;
		cmd_op    <= op;
		cmd_arg   <= arg;
		cmd_first <= first;
		do @(posedge clk_sys); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		do @(posedge clk_sys); while (cmd_ready !== 1'b1);
	endtask
	task automatic rsp(input string s);
		check(rx_n - rb, s.len());
		for (int i = 0; i < s.len(); i++) begin
			check(host_u.rx_q[rb + i][7:0], s[i]);
			check(host_u.rx_q[rb + i][8], (i + 1 == s.len()) || (s[i + 1] == ";"));
		end
		rb = rx_n;
	endtask
	task automatic test_done;
		if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// all tests need well under 2000 cycles
	initial begin
		#100000;
		error_cnt++;
		test_done;
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		check(ese_val, 8'h00);
		do_cmd(`RCCS_OP_ESE, 40'hff, 1);
		check(ese_val, 8'hff);
		do_cmd(`RCCS_OP_ESE_Q, 0, 1);
		rsp("255");
		do_cmd(`RCCS_OP_ESE, 40'h100, 1);
		check({err_count, ese_val}, 12'h1ff);
		do_cmd(`RCCS_OP_SET_BOOL, 40'h7, 1);
		check(set_bool, 1'b1);
		do_cmd(`RCCS_OP_SET_BOOL, 40'h0, 1);
		check(set_bool, 1'b0);
		do_cmd(`RCCS_OP_SET_BOOL, 40'h2, 1);
		do_cmd(`RCCS_OP_RST, 0, 1);
		check({set_bool, ese_val}, 9'h0ff);
		do_cmd(`RCCS_OP_ESR_Q, 0, 1);
		do_cmd(`RCCS_OP_ESR_Q, 0, 0);
		rsp("16;0");
		do_cmd(`RCCS_OP_OPC, 0, 1);
		check(esr_val, 8'h01);
		do_cmd(`RCCS_OP_OPC_Q, 0, 1);
		rsp("1");
		oper_evt <= 16'h0100;
		esr_evt  <= 8'h40;
		@(posedge clk_sys);
		oper_evt <= 16'h0000;
		esr_evt  <= 8'h00;
		@(posedge clk_sys);
		check({esr_val, oper_val}, 24'h410100);
		check(stb_val, 8'h24);
		do_cmd(`RCCS_OP_CLS, 0, 1);
		check({err_count, esr_val, oper_val}, 28'h0);
		@(posedge clk_sys);
		check(stb_val, 8'h00);
		slow <= 1'b1;
		do_cmd(`RCCS_OP_IDN_Q, 0, 1);
		rsp({`RCCS_IDN_MAKER, ",", `RCCS_IDN_MODEL, ",", `RCCS_IDN_SERIAL, ",", `RCCS_IDN_VER});
		slow <= 1'b0;
		do_cmd(`RCCS_OP_SET_NUM, 40'd12345, 1);
		check(set_num, 40'd12350);
		do_cmd(`RCCS_OP_SAV, 40'd9, 1);
		do_cmd(`RCCS_OP_SET_NUM, 40'd9999, 1);
		check(set_num, 40'd9999);
		do_cmd(`RCCS_OP_RCL, 40'd9, 1);
		check(set_num, 40'd12350);
		do_cmd(`RCCS_OP_SAV, 40'd0, 1);
		do_cmd(`RCCS_OP_RCL, 40'd10, 1);
		do_cmd(4'hc, 0, 1);
		check({err_count, esr_val[5:4]}, 6'h0f);
		check(set_num, 40'd12350);
		do_cmd(`RCCS_OP_RCL, 40'd0, 1);
		check(set_num, 40'h0);
		do_cmd(`RCCS_OP_SET_NUM, 40'd123456789, 1);
		check(set_num, 40'd123500000);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		check({cmd_ready, ese_val, esr_val, set_num}, 57'h1_0000_0000_0000_00);
		test_done;
	end
endmodule
`default_nettype wire
